// ### rtl/hpc_ack_retime.sv
// Retimes the acknowledge into the external acknowledge clock
`timescale 1ns/1ps
module hpc_ack_retime
    import hpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic link_rise,
    input wire logic [1:0] sync_mode,
    input wire logic ack_n_core,
    output logic ack_n
);
    logic stage1;
    logic stage2;

    // Ranks advance only on external clock edges
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
        end
        else if (link_rise)
        begin
            stage1 <= ack_n_core;
            stage2 <= stage1;
        end
    end

    always_comb
    begin
        unique case (sync_mode)
            HPC_SYNC_ONE: ack_n = stage1;
            HPC_SYNC_TWO: ack_n = stage2;
            default: ack_n = ack_n_core;
        endcase
    end
endmodule

// ### rtl/hpc_pkg.sv
// Constants for the host port control block
package hpc_pkg;
    localparam logic [7:0] HPC_CTRL_OFF = 8'h00;
    localparam logic [7:0] HPC_CORE_OFF = 8'h04;
    localparam logic [7:0] HPC_STAT_OFF = 8'h08;
    localparam int HPC_SYNC_LSB = 16;
    localparam int HPC_WAIT_LSB = 13;
    localparam int HPC_DMA_REQ_ON_INT2_BIT = 12;
    localparam int HPC_FAST_BIT = 11;
    localparam int HPC_DSUP_BIT = 10;
    localparam int HPC_ALT_BIT = 9;
    localparam int HPC_TOPW_BIT = 8;
    localparam int HPC_PEND_BIT = 7;
    localparam int HPC_AOC_BIT = 6;
    localparam int HPC_DIR2_BIT = 5;
    localparam int HPC_IOC_BIT = 4;
    localparam int HPC_DMAEN_BIT = 3;
    localparam int HPC_HOST_IRQ_ENABLE_N_BIT = 2;
    localparam int HPC_GEN_EN_BIT = 0;
    localparam int HPC_UNLOCK_BIT = 1;
    localparam logic [31:0] HPC_CTRL_RST = 32'h0000_00ac;
    localparam logic [31:0] HPC_CTRL_MASK = 32'h0003_fffc;
    localparam logic [1:0] HPC_SYNC_CORE = 2'h0;
    localparam logic [1:0] HPC_SYNC_ONE = 2'h1;
    localparam logic [1:0] HPC_SYNC_TWO = 2'h2;
    localparam logic [1:0] HPC_RANGE_64K = 2'h0;
    localparam logic [1:0] HPC_RANGE_32K = 2'h1;
    localparam logic [1:0] HPC_RANGE_8K = 2'h2;
    localparam logic [3:0] HPC_CLASSIC_CYC = 4'h4;
    localparam logic [3:0] HPC_FAST_SAVE = 4'h2;
    localparam logic [1:0] HPC_BOOT_CYC = 2'h2;
    typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT, ACC_ACK} hpc_acc_t;
endpackage

// ### rtl/hpc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module hpc_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    initial
    begin
        if (W < 1) $error("hpc_sync width must be positive");
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            meta <= '0;
            dout <= '0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ### rtl/hpc_top.sv
// Host port control register and pin personality logic
//
// How it works
// - Sync field 00 drives acknowledge from the core clock.
// - Sync field 01 retimes acknowledge through one external-clock rank.
// - Sync field 10 retimes through two ranks; 11 is reserved.
// - Wait field adds cycles before acknowledge on reads and writes.
// - Request-on-int2 drives OR of FIFO requests, active high, on int2.
// - With it set, int2 carries no interrupt; address 14 and 13 address.
// - Fast timing makes each access two core cycles shorter.
// - Suppress bit stops acknowledge during DMA cycles.
// - Alternate shared layout bit; reset default is inverted strap A7.
// - Top-word option lets a top-word host write raise pending.
// - Pending goes low on host interrupt, cleared by writing one.
// - Processor interrupt needs pending, enable low, general enable high.
// - Ack driver open drain when one; default from strap A6.
// - Int2 direction one is output by pin select; zero rising edge input.
// - Interrupt driver open drain when one; default from strap A4.
// - FIFO DMA enable low repurposes address 15..13, or 15 and int2 with request-on-int2; strap A3.
// - DMA with combined bit low gives 8K, high gives 32K range.
// - FIFO DMA disabled leaves address pins and int2 normal.
// - Host interrupts accepted only with enable low; three sources.
// - Control register written from the processor bus, by strap capture at boot, and pending by host interrupts.
// - After strap capture, control bits 6 to 2 change only while unlock is set.
`timescale 1ns/1ps
module hpc_top
    import hpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_select_n,
    input wire logic host_dma_ack,
    input wire logic host_rw,
    input wire logic ext_ack_clock_pin,
    input wire logic [15:13] host_addr_pin,
    input wire logic [7:2] boot_addr_pin,
    input wire logic host_int2_pin,
    input wire logic host_irq_req,
    input wire logic int_pin_select,
    input wire logic shared_host_irq_flag,
    input wire logic top_word_write,
    input wire logic fifo_in_req_n,
    input wire logic fifo_out_req_n,
    output logic host_ack_out,
    output logic host_ack_oe,
    output logic host_int1_line,
    output logic host_int1_oe,
    output logic host_int2_line,
    output logic host_int2_oe,
    output logic [14:13] host_addr_out,
    output logic [14:13] host_addr_oe,
    output logic fifo_dma_ack_n,
    output logic [15:13] host_addr_eff,
    output logic [1:0] ram_range,
    output logic shared_reg_alt_format,
    output logic host_write,
    output logic cpu_irq
);
    logic [13:0] pins_s;
    logic sel_s, fifo_dma_ack_n_s, rw_s, lclk_s, int2_s;
    logic [15:13] addr_s;
    logic [7:2] boot_s;
    logic lclk_d, int2_d, link_rise;
    logic [31:0] ctrl;
    logic gen_host_irq_enable, mode_unlock;
    logic [1:0] boot_cnt;
    logic boot_done;
    hpc_acc_t acc_state;
    logic [3:0] acc_cnt;
    logic dma_cyc;
    logic ack_n_core, ack_n_ret;
    logic acc_req;
    logic wr_ok, rd_setup, mapped;
    logic host_irq_event;
    logic [31:0] next_rdata;
    logic int2_sel;

    logic [1:0] sync_mode;
    logic [2:0] wait_states;
    logic dma_req_on_int2, fast, dma_ack_suppress, top_word_write_irq;
    logic host_irq_pending_n, ack_open_drain, int2_direction, irq_open_drain;
    logic fifo_dma_enable_n, host_irq_enable_n;

    assign sync_mode = ctrl[HPC_SYNC_LSB +: 2];
    assign wait_states = ctrl[HPC_WAIT_LSB +: 3];
    assign dma_req_on_int2 = ctrl[HPC_DMA_REQ_ON_INT2_BIT];
    assign fast = ctrl[HPC_FAST_BIT];
    assign dma_ack_suppress = ctrl[HPC_DSUP_BIT];
    assign top_word_write_irq = ctrl[HPC_TOPW_BIT];
    assign host_irq_pending_n = ctrl[HPC_PEND_BIT];
    assign ack_open_drain = ctrl[HPC_AOC_BIT];
    assign int2_direction = ctrl[HPC_DIR2_BIT];
    assign irq_open_drain = ctrl[HPC_IOC_BIT];
    assign fifo_dma_enable_n = ctrl[HPC_DMAEN_BIT];
    assign host_irq_enable_n = ctrl[HPC_HOST_IRQ_ENABLE_N_BIT];

    hpc_sync #(.W(14)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .din({host_select_n, host_dma_ack, host_rw, ext_ack_clock_pin,
              host_int2_pin, host_addr_pin, boot_addr_pin}),
        .dout(pins_s)
    );
    assign {sel_s, fifo_dma_ack_n_s, rw_s, lclk_s, int2_s, addr_s, boot_s} = pins_s;

    // DMA acknowledge exists only while FIFO DMA is on
    assign acc_req = !sel_s || (!fifo_dma_enable_n && !addr_s[15]);
    assign link_rise = lclk_s && !lclk_d;
    assign wr_ok = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;
    assign mapped = (paddr == HPC_CTRL_OFF) || (paddr == HPC_CORE_OFF)
        || (paddr == HPC_STAT_OFF);

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            lclk_d <= 1'b0;
            int2_d <= 1'b0;
        end
        else
        begin
            lclk_d <= lclk_s;
            int2_d <= int2_s;
        end
    end

    // Three interrupt sources, gated by the enable
    always_comb
    begin
        host_irq_event = 1'b0;
        if (!host_irq_enable_n)
        begin
            host_irq_event = shared_host_irq_flag
                || (top_word_write_irq && top_word_write)
                || (!int2_direction && !dma_req_on_int2 && int2_s && !int2_d);
        end
    end

    // Strap capture after the synchroniser has filled
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            boot_cnt <= '0;
            boot_done <= 1'b0;
        end
        else if (!boot_done)
        begin
            boot_cnt <= boot_cnt + 2'h1;
            boot_done <= (boot_cnt == HPC_BOOT_CYC);
        end
    end

    // Control register: processor bus, boot strap capture, host interrupt sets pending (drives the bit low)
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl <= HPC_CTRL_RST;
        end
        else if (!boot_done && boot_cnt == HPC_BOOT_CYC)
        begin
            ctrl[HPC_ALT_BIT] <= !boot_s[7];
            ctrl[HPC_AOC_BIT] <= boot_s[6];
            ctrl[HPC_DIR2_BIT] <= boot_s[5];
            ctrl[HPC_IOC_BIT] <= boot_s[4];
            ctrl[HPC_DMAEN_BIT] <= boot_s[3];
            ctrl[HPC_HOST_IRQ_ENABLE_N_BIT] <= boot_s[2];
        end
        else
        begin
            if (wr_ok && paddr == HPC_CTRL_OFF)
            begin
                ctrl[31:8] <= pwdata[31:8] & HPC_CTRL_MASK[31:8];
                if (mode_unlock)
                begin
                    ctrl[6:2] <= pwdata[6:2];
                end
                if (pwdata[HPC_PEND_BIT])
                begin
                    ctrl[HPC_PEND_BIT] <= 1'b1;
                end
            end
            if (host_irq_event)
            begin
                ctrl[HPC_PEND_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            gen_host_irq_enable <= 1'b0;
            mode_unlock <= 1'b0;
        end
        else if (wr_ok && paddr == HPC_CORE_OFF)
        begin
            gen_host_irq_enable <= pwdata[HPC_GEN_EN_BIT];
            mode_unlock <= pwdata[HPC_UNLOCK_BIT];
        end
    end

    always_comb
    begin
        next_rdata = '0;
        if (paddr == HPC_CTRL_OFF)
        begin
            next_rdata = ctrl & HPC_CTRL_MASK;
            next_rdata[HPC_PEND_BIT] = host_irq_pending_n;
        end
        else if (paddr == HPC_CORE_OFF)
        begin
            next_rdata[HPC_GEN_EN_BIT] = gen_host_irq_enable;
            next_rdata[HPC_UNLOCK_BIT] = mode_unlock;
        end
        else if (paddr == HPC_STAT_OFF)
        begin
            next_rdata[0] = cpu_irq;
            next_rdata[1] = host_irq_pending_n;
            next_rdata[3:2] = ram_range;
            next_rdata[4] = (acc_state != ACC_IDLE);
        end
    end

    // No wait states: ready in the first access-phase cycle
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= rd_setup;
            pslverr <= rd_setup && !mapped;
            if (rd_setup)
            begin
                prdata <= next_rdata;
            end
        end
    end

    // Host access sequencer
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            acc_state <= ACC_IDLE;
            acc_cnt <= '0;
            dma_cyc <= 1'b0;
            host_write <= 1'b0;
        end
        else
        begin
            unique case (acc_state)
                ACC_IDLE:
                begin
                    if (acc_req)
                    begin
                        acc_state <= ACC_WAIT;
                        acc_cnt <= (fast ? HPC_CLASSIC_CYC - HPC_FAST_SAVE : HPC_CLASSIC_CYC)
                            + {1'b0, wait_states} - 4'h1;
                        dma_cyc <= sel_s;
                        if (fast)
                        begin
                            host_write <= !rw_s;
                        end
                    end
                end
                ACC_WAIT:
                begin
                    if (!acc_req)
                    begin
                        acc_state <= ACC_IDLE;
                    end
                    else if (acc_cnt == 4'h0)
                    begin
                        acc_state <= ACC_ACK;
                        if (!fast)
                        begin
                            host_write <= !rw_s;
                        end
                    end
                    else
                    begin
                        acc_cnt <= acc_cnt - 4'h1;
                    end
                end
                ACC_ACK:
                begin
                    if (!acc_req)
                    begin
                        acc_state <= ACC_IDLE;
                    end
                end
            endcase
        end
    end

    // Core-domain acknowledge, low active
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ack_n_core <= 1'b1;
        end
        else
        begin
            ack_n_core <= !(acc_state == ACC_ACK && acc_req
                && !(dma_cyc && dma_ack_suppress));
        end
    end

    hpc_ack_retime u_retime (
        .core_clk(core_clk),
        .reset(reset),
        .link_rise(link_rise),
        .sync_mode(sync_mode),
        .ack_n_core(ack_n_core),
        .ack_n(ack_n_ret)
    );

    // Pin drivers and personality
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            host_ack_out <= 1'b1;
            host_ack_oe <= 1'b0;
            host_int1_line <= 1'b1;
            host_int1_oe <= 1'b0;
            host_int2_line <= 1'b1;
            host_int2_oe <= 1'b0;
            host_addr_out <= '0;
            host_addr_oe <= '0;
            fifo_dma_ack_n <= 1'b1;
            host_addr_eff <= '0;
            ram_range <= HPC_RANGE_64K;
            shared_reg_alt_format <= 1'b0;
            cpu_irq <= 1'b0;
        end
        else
        begin
            host_ack_out <= ack_open_drain ? 1'b0 : ack_n_ret;
            host_ack_oe <= ack_open_drain ? !ack_n_ret : 1'b1;
            shared_reg_alt_format <= ctrl[HPC_ALT_BIT];
            cpu_irq <= !host_irq_pending_n && !host_irq_enable_n && gen_host_irq_enable;
            // Int1 carries host request unless int2 is selected
            host_int1_line <= irq_open_drain ? 1'b0 : !(host_irq_req && !int2_sel);
            host_int1_oe <= irq_open_drain ? (host_irq_req && !int2_sel) : 1'b1;
            if (!fifo_dma_enable_n && dma_req_on_int2)
            begin
                host_int2_line <= !fifo_in_req_n || !fifo_out_req_n;
                host_int2_oe <= 1'b1;
            end
            else if (int2_direction)
            begin
                host_int2_line <= irq_open_drain ? 1'b0 : !(host_irq_req && int2_sel);
                host_int2_oe <= irq_open_drain ? (host_irq_req && int2_sel) : 1'b1;
            end
            else
            begin
                host_int2_line <= 1'b1;
                host_int2_oe <= 1'b0;
            end
            if (fifo_dma_enable_n)
            begin
                fifo_dma_ack_n <= 1'b1;
                host_addr_out <= '0;
                host_addr_oe <= '0;
                host_addr_eff <= addr_s;
                ram_range <= HPC_RANGE_64K;
            end
            else if (dma_req_on_int2)
            begin
                fifo_dma_ack_n <= addr_s[15];
                host_addr_out <= '0;
                host_addr_oe <= '0;
                host_addr_eff <= {1'b0, addr_s[14:13]};
                ram_range <= HPC_RANGE_32K;
            end
            else
            begin
                fifo_dma_ack_n <= addr_s[15];
                host_addr_out <= {fifo_out_req_n, fifo_in_req_n};
                host_addr_oe <= 2'h3;
                host_addr_eff <= '0;
                ram_range <= HPC_RANGE_8K;
            end
        end
    end

    assign int2_sel = int2_direction && !dma_req_on_int2 && int_pin_select;

    // Helper: cycles spent waiting for acknowledge
    logic [4:0] wait_seen;
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            wait_seen <= '0;
        end
        else
        begin
            wait_seen <= (acc_state == ACC_WAIT) ? wait_seen + 5'h1 : 5'h0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_WAIT_LEN: assert property (
        acc_state == ACC_WAIT && acc_req && acc_cnt == 4'h0 |->
        wait_seen == 5'(fast ? HPC_CLASSIC_CYC - HPC_FAST_SAVE : HPC_CLASSIC_CYC)
            + 5'(wait_states) - 5'h1)
        else $error("wait length wrong");
    AST_FAST: assert property (
        acc_state == ACC_IDLE && acc_req && fast && wait_states == 3'h0
        |=> acc_state == ACC_WAIT ##1 acc_state == ACC_WAIT && acc_cnt == 4'h0
            || !acc_req)
        else $error("fast access not shortened");
    AST_SYNC0: assert property (
        sync_mode == HPC_SYNC_CORE && !ack_open_drain |=> host_ack_out == $past(ack_n_core))
        else $error("core acknowledge not followed");
    AST_DSUP: assert property (
        dma_cyc && dma_ack_suppress && $stable(dma_ack_suppress) |=> ack_n_core)
        else $error("acknowledge during suppressed DMA");
    AST_PEND_SET: assert property (
        host_irq_event |=> !host_irq_pending_n)
        else $error("pending not set");
    AST_PEND_HOLD: assert property (
        !host_irq_pending_n && !(wr_ok && paddr == HPC_CTRL_OFF) |=> !host_irq_pending_n)
        else $error("pending dropped without clear");
    AST_IRQ: assert property (
        cpu_irq |-> $past(!host_irq_pending_n && !host_irq_enable_n && gen_host_irq_enable))
        else $error("spurious processor interrupt");
    AST_NOACC: assert property (
        host_irq_enable_n && host_irq_pending_n && !wr_ok |=> host_irq_pending_n)
        else $error("interrupt taken while disabled");
    AST_LOCK: assert property (
        !mode_unlock && boot_done |=> ctrl[6:2] == $past(ctrl[6:2]))
        else $error("locked bits changed");
    AST_REQ2: assert property (
        !fifo_dma_enable_n && dma_req_on_int2 && $stable(ctrl) |=>
        host_int2_oe && host_int2_line == $past(!fifo_in_req_n || !fifo_out_req_n))
        else $error("int2 request wrong");
    AST_RANGE: assert property (
        !fifo_dma_enable_n && !dma_req_on_int2 && $stable(ctrl) |=> ram_range == HPC_RANGE_8K)
        else $error("range not limited");

    COV_ACK: cover property (acc_state == ACC_WAIT ##1 acc_state == ACC_ACK);
    COV_IRQ: cover property (host_irq_event ##1 !host_irq_pending_n);
    COV_RET: cover property (sync_mode == HPC_SYNC_TWO && link_rise);
endmodule

// ### test/hpc_host_model.sv
// Client processor model driving select and read/write on the host port
`timescale 1ns/1ps
module hpc_host_model (
    input wire logic core_clk,
    input wire logic host_ack_out,
    output logic host_select_n,
    output logic host_rw
);
    initial
    begin
        host_select_n = 1'b1;
        host_rw = 1'b0;
    end
    // One host cycle, n counts cycles from select to acknowledge
    task automatic access(input logic rd, input int lim, output int n);
        @(posedge core_clk);
        host_rw <= rd;
        @(posedge core_clk);
        host_select_n <= 1'b0;
        n = 0;
        while (host_ack_out !== 1'b0 && n < lim)
        begin
            @(posedge core_clk);
            n++;
        end
        host_select_n <= 1'b1;
        @(posedge core_clk);
        host_rw <= ~rd;
        repeat (24) @(posedge core_clk);
    endtask
endmodule

// ### test/hpc_top_tb.sv
// Self-checking bench for the host port control block
`timescale 1ns/1ps
module hpc_top_tb;
    import hpc_pkg::*;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic host_select_n, host_rw, ext_ack_clock_pin, host_ack_out;
    logic flag_pulse, top_pulse, in_req_n, host_int2_line, shared_reg_alt_format, cpu_irq;
    logic int2_pin, host_write, fifo_dma_ack_n;
    logic [15:13] host_addr_pin;
    logic [1:0] ram_range;
    int err_count, comparisons, l0, l3, lw, lf, s1, s2, s3, n;
    hpc_top i_hpc_top (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_select_n(host_select_n), .host_dma_ack(1'b1),
        .host_rw(host_rw), .ext_ack_clock_pin(ext_ack_clock_pin),
        .host_addr_pin(host_addr_pin), .boot_addr_pin(6'h0b), .host_int2_pin(int2_pin),
        .host_irq_req(1'b0), .int_pin_select(1'b0), .shared_host_irq_flag(flag_pulse),
        .top_word_write(top_pulse), .fifo_in_req_n(in_req_n), .fifo_out_req_n(1'b1),
        .host_ack_out(host_ack_out), .host_ack_oe(), .host_int1_line(), .host_int1_oe(),
        .host_int2_line(host_int2_line), .host_int2_oe(), .host_addr_out(),
        .host_addr_oe(), .fifo_dma_ack_n(fifo_dma_ack_n), .host_addr_eff(),
        .ram_range(ram_range), .shared_reg_alt_format(shared_reg_alt_format),
        .host_write(host_write), .cpu_irq(cpu_irq));
    hpc_host_model i_hpc_host_model (.core_clk(core_clk), .host_ack_out(host_ack_out),
        .host_select_n(host_select_n), .host_rw(host_rw));
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        ext_ack_clock_pin = 1'b0;
        #137;
        forever #400 ext_ack_clock_pin = ~ext_ack_clock_pin;
    end
    task automatic report_and_stop();
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // APB transfer: setup, then access phase until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
        begin
            if (k == 20)
            begin
                err_count++;
                report_and_stop();
            end
            @(posedge core_clk);
            k++;
        end
        q = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic lat(input logic [31:0] c, input logic rd, output int m);
        apb(1'b1, HPC_CTRL_OFF, c);
        i_hpc_host_model.access(rd, 80, m);
    endtask
    task automatic dma(input logic [31:0] c, output int m);
        apb(1'b1, HPC_CTRL_OFF, c);
        host_addr_pin <= 3'b011;
        m = 0;
        while (host_ack_out !== 1'b0 && m < 40)
        begin
            @(posedge core_clk);
            m++;
        end
        chk({31'h0, fifo_dma_ack_n}, 32'h0);
        host_addr_pin <= 3'b111;
        repeat (6) @(posedge core_clk);
    endtask
    initial
    begin
        repeat (100000) @(posedge core_clk);
        err_count++;
        report_and_stop();
    end
    initial
    begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {flag_pulse, top_pulse} = 2'b00;
        in_req_n = 1'b1;
        host_addr_pin = 3'b111;
        int2_pin = 1'b0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        repeat (6) @(posedge core_clk);
        apb(1'b0, HPC_CTRL_OFF, 32'h0);
        chk(q, 32'h0000_02ac);
        chk({31'h0, shared_reg_alt_format}, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        chk({q[30:0], rd_err}, 32'h1);
        apb(1'b1, HPC_CTRL_OFF, 32'h0000_0290);
        apb(1'b0, HPC_CTRL_OFF, 32'h0);
        chk(q, 32'h0000_02ac);
        apb(1'b1, HPC_CORE_OFF, 32'h3);
        apb(1'b1, HPC_CTRL_OFF, 32'h0000_0290);
        apb(1'b0, HPC_CTRL_OFF, 32'h0);
        chk(q, 32'h0000_0290);
        chk({30'h0, ram_range}, {30'h0, HPC_RANGE_8K});
        apb(1'b1, HPC_CTRL_OFF, 32'h0000_1290);
        chk({30'h0, ram_range}, {30'h0, HPC_RANGE_32K});
        in_req_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk({31'h0, host_int2_line}, 32'h1);
        in_req_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({31'h0, host_int2_line}, 32'h0);
        apb(1'b1, HPC_CTRL_OFF, 32'h0000_0298);
        chk({30'h0, ram_range}, {30'h0, HPC_RANGE_64K});
        lat(32'h0000_0298, 1'b1, l0);
        lat(32'h0000_6298, 1'b1, l3);
        chk(32'(l3 - l0), 32'h3);
        lat(32'h0000_6298, 1'b0, lw);
        chk(32'(lw), 32'(l3));
        chk({31'h0, host_write}, 32'h1);
        lat(32'h0000_6a98, 1'b1, lf);
        chk(32'(l3 - lf), 32'h2);
        lat(32'h0001_0298, 1'b1, s1);
        chk({31'h0, s1 > l0 && s1 < 80}, 32'h1);
        lat(32'h0002_0298, 1'b1, s2);
        chk({31'h0, s2 > l0 && s2 < 80}, 32'h1);
        lat(32'h0003_0298, 1'b1, s3);
        chk(32'(s3), 32'(l0));
        dma(32'h0000_0290, n);
        chk({31'h0, n < 40}, 32'h1);
        dma(32'h0000_0690, n);
        chk(32'(n), 32'd40);
        for (int s = 1; s < 3; s++)
        begin
            apb(1'b1, HPC_CTRL_OFF, 32'h0000_0398);
            {top_pulse, flag_pulse} <= 2'(s);
            @(posedge core_clk);
            {top_pulse, flag_pulse} <= 2'b00;
            repeat (3) @(posedge core_clk);
            chk({31'h0, cpu_irq}, 32'h1);
            apb(1'b0, HPC_CTRL_OFF, 32'h0);
            chk({31'h0, q[HPC_PEND_BIT]}, 32'h0);
            apb(1'b1, HPC_CTRL_OFF, 32'h0000_0398);
            apb(1'b0, HPC_CTRL_OFF, 32'h0);
            chk({31'h0, q[HPC_PEND_BIT]}, 32'h1);
        end
        int2_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk({31'h0, cpu_irq}, 32'h1);
        int2_pin <= 1'b0;
        apb(1'b1, HPC_CTRL_OFF, 32'h0000_0398);
        apb(1'b1, HPC_CTRL_OFF, 32'h0000_039c);
        flag_pulse <= 1'b1;
        @(posedge core_clk);
        flag_pulse <= 1'b0;
        repeat (3) @(posedge core_clk);
        apb(1'b0, HPC_CTRL_OFF, 32'h0);
        chk({31'h0, q[HPC_PEND_BIT]}, 32'h1);
        chk({31'h0, cpu_irq}, 32'h0);
        report_and_stop();
    end
endmodule
